// ---- logic/gpsync_defines.vh ----
// Register offsets, field positions, reset values and sizes for the port block.
`ifndef GPSYNC_DEFINES_VH
`define GPSYNC_DEFINES_VH

// =====================================================================
// Port geometry
`define GPS_NPINS          8
`define GPS_INT_PINS       2

// =====================================================================
// Register byte offsets
`define GPS_OFF_DIR        8'h00
`define GPS_OFF_DRV        8'h04
`define GPS_OFF_SENSE      8'h08
`define GPS_OFF_SPECIAL    8'h0C
`define GPS_OFF_DIR_SET    8'h10
`define GPS_OFF_DIR_CLR    8'h14
`define GPS_OFF_DRV_SET    8'h18
`define GPS_OFF_DRV_CLR    8'h1C
`define GPS_OFF_INT_CFG    8'h20
`define GPS_OFF_INT_FLAG   8'h24

// =====================================================================
// Fields
`define GPS_PUD_BIT        2
`define GPS_RST_BYTE       8'h00
`define GPS_RST_BIT        1'b0
`define GPS_RST_INT        2'h0
`define GPS_PIN_OFF_N      1'b1
`define GPS_PIN_LOW        1'b0

// =====================================================================
// Bus answers
`define GPS_RESP_OKAY      2'h0
`define GPS_RESP_SLVERR    2'h2
`define GPS_RDATA_ZERO     32'h00000000

`endif

// ---- logic/gpsync_port.v ----
// One eight-pin general-purpose port with an AXI4-Lite register slave.
//
// Our own choices: the register offsets and the AXI4-Lite register port.
`timescale 1ns/1ns
`include "gpsync_defines.vh"

// =====================================================================
module gpsync_port (
    // Clock and reset
    input  wire        CLK_SYS,
    input  wire        RST_N,
    // AXI4-Lite write address and data
    input  wire [7:0]  AWADDR,
    input  wire        AWVALID,
    output wire        AWREADY,
    input  wire [31:0] WDATA,
    input  wire [3:0]  WSTRB,
    input  wire        WVALID,
    output wire        WREADY,
    // AXI4-Lite write response
    output reg  [1:0]  BRESP,
    output reg         BVALID,
    input  wire        BREADY,
    // AXI4-Lite read
    input  wire [7:0]  ARADDR,
    input  wire        ARVALID,
    output wire        ARREADY,
    output reg  [31:0] RDATA,
    output reg  [1:0]  RRESP,
    output reg         RVALID,
    input  wire        RREADY,
    // Pins, output enable low while driving
    input  wire [7:0]  PIN_IN,
    output wire [7:0]  PIN_OUT,
    output wire [7:0]  PIN_OE_N,
    output wire [7:0]  PIN_PULLUP,
    // Sleep controller and alternate-function input override
    input  wire        SLEEP_DEEP,
    input  wire [7:0]  ALT_INPUT_KEEP,
    // External interrupt pins 0 and 1 flag outputs
    output wire [1:0]  EXT_INT_FLAG
);

    // =====================================================================
    // Storage
    reg  [7:0] dir_reg;
    reg  [7:0] drv_reg;
    reg        pud_reg;
    reg  [1:0] int_en_reg;
    reg  [1:0] int_edge_reg;
    reg  [1:0] int_flag_reg;
    reg  [1:0] clamp_prev_reg;
    reg        aw_full_reg;
    reg        w_full_reg;
    reg  [7:0] aw_addr_reg;
    reg [31:0] w_data_reg;
    reg        w_strb0_reg;

    reg  [7:0] dir_next;
    reg  [7:0] drv_next;
    reg  [1:0] wr_resp;
    reg [31:0] rd_word;
    reg  [1:0] rd_resp;
    wire [1:0] int_clr;
    wire [1:0] int_flag_next;
    wire       do_write;
    wire [7:0] wbyte;
    wire [7:0] clamp_on;
    wire [7:0] sense_bits;
    wire [1:0] clamp_edge;
    genvar     gi;

    // =====================================================================
    // Pin cells
    // sleep clamp
    assign clamp_on = {8{SLEEP_DEEP}} & ~ALT_INPUT_KEEP
                      & ~{6'h00, int_en_reg};

    // one cell per pin
    // Each pin owns its synchroniser, so pins never share a sampling stage.
    // The global disable fans out to every cell as one common bit.
    generate
        for (gi = 0; gi < `GPS_NPINS; gi = gi + 1) begin : g_pin
            gpsync_pin_cell gpsync_pin_cell_i (
                .clk_sys    (CLK_SYS),
                .rst_n      (RST_N),
                .dir_bit    (dir_reg[gi]),
                .drv_bit    (drv_reg[gi]),
                .pud_bit    (pud_reg),
                .clamp_bit  (clamp_on[gi]),
                .pin_level  (PIN_IN[gi]),
                .pin_out    (PIN_OUT[gi]),
                .pin_oe_n   (PIN_OE_N[gi]),
                .pin_pullup (PIN_PULLUP[gi]),
                .sense_reg  (sense_bits[gi])
            );
        end
    endgenerate

    // =====================================================================
    // Clamp-made interrupt flags
    // rising clamp on a high pin
    assign clamp_edge = clamp_on[1:0] & ~clamp_prev_reg & PIN_IN[1:0]
                        & int_edge_reg & ~int_en_reg;
    // Set beats a software clear in the same cycle.
    assign int_clr = (do_write && aw_addr_reg == `GPS_OFF_INT_FLAG
                      && w_strb0_reg) ? w_data_reg[1:0] : `GPS_RST_INT;
    assign int_flag_next = (int_flag_reg & ~int_clr) | clamp_edge;
    assign EXT_INT_FLAG = int_flag_reg;

    // The history makes a flag fire once per clamp start, not every cycle.
    always @(posedge CLK_SYS or negedge RST_N) begin
        if (!RST_N) begin
            int_flag_reg   <= `GPS_RST_INT;
            clamp_prev_reg <= `GPS_RST_INT;
        end else begin
            int_flag_reg   <= int_flag_next;
            clamp_prev_reg <= clamp_on[1:0];
        end
    end

    // =====================================================================
    // AXI4-Lite write side
    // Address and data slots let the two write channels land in any order.
    // A held answer blocks new writes, so one write is under way at a time.
    assign AWREADY  = ~aw_full_reg & ~BVALID;
    assign WREADY   = ~w_full_reg & ~BVALID;
    assign do_write = aw_full_reg & w_full_reg & ~BVALID;
    assign wbyte    = w_data_reg[7:0];

    // set and clear locations
    // Set and clear locations spare software a read-modify-write.
    always @* begin
        dir_next = dir_reg;
        drv_next = drv_reg;
        case (aw_addr_reg)
            `GPS_OFF_DIR: begin
                dir_next = wbyte;
            end
            `GPS_OFF_DIR_SET: begin
                dir_next = dir_reg | wbyte;
            end
            `GPS_OFF_DIR_CLR: begin
                dir_next = dir_reg & ~wbyte;
            end
            `GPS_OFF_DRV: begin
                drv_next = wbyte;
            end
            `GPS_OFF_DRV_SET: begin
                drv_next = drv_reg | wbyte;
            end
            `GPS_OFF_DRV_CLR: begin
                drv_next = drv_reg & ~wbyte;
            end
            default: begin
                dir_next = dir_reg;
            end
        endcase
    end

    // Writes to the sense location are refused and change nothing.
    always @* begin
        wr_resp = `GPS_RESP_SLVERR;
        case (aw_addr_reg)
            `GPS_OFF_DIR, `GPS_OFF_DRV, `GPS_OFF_SPECIAL,
            `GPS_OFF_DIR_SET, `GPS_OFF_DIR_CLR, `GPS_OFF_DRV_SET,
            `GPS_OFF_DRV_CLR, `GPS_OFF_INT_CFG,
            `GPS_OFF_INT_FLAG: begin
                wr_resp = `GPS_RESP_OKAY;
            end
            default: begin
                wr_resp = `GPS_RESP_SLVERR;
            end
        endcase
    end

    always @(posedge CLK_SYS or negedge RST_N) begin
        if (!RST_N) begin
            dir_reg      <= `GPS_RST_BYTE;
            drv_reg      <= `GPS_RST_BYTE;
            pud_reg      <= `GPS_RST_BIT;
            int_en_reg   <= `GPS_RST_INT;
            int_edge_reg <= `GPS_RST_INT;
            aw_full_reg  <= `GPS_RST_BIT;
            w_full_reg   <= `GPS_RST_BIT;
            aw_addr_reg  <= `GPS_RST_BYTE;
            w_data_reg   <= `GPS_RDATA_ZERO;
            w_strb0_reg  <= `GPS_RST_BIT;
            BVALID       <= `GPS_RST_BIT;
            BRESP        <= `GPS_RESP_OKAY;
        end else begin
            if (AWVALID && AWREADY) begin
                aw_full_reg <= 1'b1;
                aw_addr_reg <= {AWADDR[7:2], 2'b00};
            end
            if (WVALID && WREADY) begin
                w_full_reg  <= 1'b1;
                w_data_reg  <= WDATA;
                w_strb0_reg <= WSTRB[0];
            end
            if (do_write) begin
                aw_full_reg <= 1'b0;
                w_full_reg  <= 1'b0;
                BVALID      <= 1'b1;
                BRESP       <= wr_resp;
                if (w_strb0_reg) begin
                    dir_reg <= dir_next;
                    drv_reg <= drv_next;
                    if (aw_addr_reg == `GPS_OFF_SPECIAL) begin
                        pud_reg <= w_data_reg[`GPS_PUD_BIT];
                    end
                    if (aw_addr_reg == `GPS_OFF_INT_CFG) begin
                        int_en_reg   <= w_data_reg[1:0];
                        int_edge_reg <= w_data_reg[9:8];
                    end
                end
            end else if (BVALID && BREADY) begin
                BVALID <= 1'b0;
            end
        end
    end

    // =====================================================================
    // AXI4-Lite read side
    assign ARREADY = ~RVALID;

    always @* begin
        rd_word = `GPS_RDATA_ZERO;
        rd_resp = `GPS_RESP_OKAY;
        case ({ARADDR[7:2], 2'b00})
            `GPS_OFF_DIR:      rd_word = {24'h000000, dir_reg};
            `GPS_OFF_DRV:      rd_word = {24'h000000, drv_reg};
            `GPS_OFF_SENSE:    rd_word = {24'h000000, sense_bits};
            `GPS_OFF_SPECIAL:  rd_word = {29'h00000000, pud_reg, 2'b00};
            `GPS_OFF_INT_CFG:  rd_word = {22'h000000, int_edge_reg,
                                          6'h00, int_en_reg};
            `GPS_OFF_INT_FLAG: rd_word = {30'h00000000, int_flag_reg};
            default: begin
                rd_resp = `GPS_RESP_SLVERR;
            end
        endcase
    end

    // Only one read in flight: a new address waits until RDATA is taken.
    always @(posedge CLK_SYS or negedge RST_N) begin
        if (!RST_N) begin
            RVALID <= 1'b0;
            RDATA  <= `GPS_RDATA_ZERO;
            RRESP  <= `GPS_RESP_OKAY;
        end else if (ARVALID && ARREADY) begin
            RVALID <= 1'b1;
            RDATA  <= rd_word;
            RRESP  <= rd_resp;
        end else if (RVALID && RREADY) begin
            RVALID <= 1'b0;
        end
    end

endmodule

// =====================================================================
// One pin: its drivers, its pull-up choice and its input synchroniser.
module gpsync_pin_cell (
    // Clock and reset
    input  wire clk_sys,
    input  wire rst_n,
    // Pin configuration
    input  wire dir_bit,
    input  wire drv_bit,
    input  wire pud_bit,
    input  wire clamp_bit,
    // Pin side, output enable low while driving
    input  wire pin_level,
    output wire pin_out,
    output wire pin_oe_n,
    output wire pin_pullup,
    // Synchronised pin level
    output reg  sense_reg
);

    reg  latch_reg;
    wire pullup_on;
    wire din;

    // Reset overrides every setting at once, even with the clock stopped.
    // direction to enable
    assign pin_oe_n   = rst_n ? ~dir_bit : `GPS_PIN_OFF_N;
    assign pin_out    = rst_n ? (drv_bit & dir_bit) : `GPS_PIN_LOW;
    assign pullup_on  = ~dir_bit & drv_bit & ~pud_bit;
    assign pin_pullup = rst_n ? pullup_on : `GPS_PIN_LOW;

    // clamp ahead of the synchroniser
    // A clamped input cannot float and burn power while the part sleeps.
    assign din = pin_level & ~clamp_bit;

    // latch stage
    // Latching on the falling edge gives the pin half a cycle to settle.
    always @(negedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            latch_reg <= `GPS_RST_BIT;
        end else begin
            latch_reg <= din;
        end
    end

    always @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            sense_reg <= `GPS_RST_BIT;
        end else begin
            sense_reg <= latch_reg;
        end
    end

endmodule

// ---- test/gpsync_pins.sv ----
// Board-side model of the eight port pins.
`timescale 1ns/1ns
module gpsync_pins (
    // Pin side of the port
    input  wire [7:0] pin_out,
    input  wire [7:0] pin_oe_n,
    input  wire [7:0] pin_pullup,
    // Level the board puts on a released pin
    input  wire [7:0] ext_level,
    // Resolved wire level
    output wire [7:0] pin_in
);
    // Wire level.
    // The board always holds a defined level, so no pin floats to an unknown.
    assign pin_in = (~pin_oe_n & pin_out) | (pin_oe_n & pin_pullup)
                  | (pin_oe_n & ~pin_pullup & ext_level);
endmodule

// ---- test/gpsync_port_sva.sv ----
// Assertions on the port block's pins and register bus.
`timescale 1ns/1ns
module gpsync_port_sva (
    input wire        CLK_SYS,
    input wire        RST_N,
    input wire        AWVALID,
    input wire        AWREADY,
    input wire        WVALID,
    input wire        WREADY,
    input wire [1:0]  BRESP,
    input wire        BVALID,
    input wire        BREADY,
    input wire        ARVALID,
    input wire        ARREADY,
    input wire [31:0] RDATA,
    input wire        RVALID,
    input wire        RREADY,
    input wire [7:0]  PIN_OUT,
    input wire [7:0]  PIN_OE_N,
    input wire [7:0]  PIN_PULLUP
);
    default clocking cb @(posedge CLK_SYS); endclocking
    default disable iff (!RST_N);
    sequence s_wr_take;
        AWVALID && AWREADY && WVALID && WREADY;
    endsequence
    sequence s_wr_ans;
        !BVALID ##1 BVALID;
    endsequence
    a_reset_tri: assert property (disable iff (1'b0)
        !RST_N |-> PIN_OE_N == 8'hFF && PIN_PULLUP == 8'h00)
        else $error("pins not released in reset");
    a_pull_output: assert property ((PIN_PULLUP & ~PIN_OE_N) == 8'h00)
        else $error("pull-up on a driven pin");
    a_out_idle: assert property ((PIN_OUT & PIN_OE_N) == 8'h00)
        else $error("drive level on an input pin");
    a_cfg_write: assert property (
        !$stable({PIN_OE_N, PIN_PULLUP, PIN_OUT}) |-> $rose(BVALID))
        else $error("pin setting changed without a write");
    a_wr_answer: assert property (s_wr_take |=> s_wr_ans)
        else $error("write answer late or early");
    a_rd_answer: assert property (
        ARVALID && ARREADY |=> RVALID && !ARREADY)
        else $error("read answer late");
    a_b_stands: assert property (
        BVALID && !BREADY |=> BVALID && $stable(BRESP))
        else $error("write answer dropped");
    a_r_stands: assert property (
        RVALID && !RREADY |=> RVALID && $stable(RDATA))
        else $error("read answer dropped");
endmodule
bind gpsync_port gpsync_port_sva gpsync_port_sva_i (.*);

// ---- test/testbench.sv ----
// Self-checking bench for the port block.
`timescale 1ns/1ns
`include "gpsync_defines.vh"
module testbench;
    reg         CLK_SYS = 1'b0, RST_N = 1'b0, SLEEP_DEEP = 1'b0;
    reg  [7:0]  AWADDR = 8'h00, ARADDR = 8'h00;
    reg  [31:0] WDATA = 32'h00000000;
    reg         AWVALID = 1'b0, WVALID = 1'b0, BREADY = 1'b0;
    reg         ARVALID = 1'b0, RREADY = 1'b0;
    reg  [7:0]  ALT_INPUT_KEEP = 8'h00, ext_level = 8'hA5;
    wire        AWREADY, WREADY, BVALID, ARREADY, RVALID;
    wire [1:0]  BRESP, RRESP, EXT_INT_FLAG;
    wire [31:0] RDATA;
    wire [7:0]  PIN_IN, PIN_OUT, PIN_OE_N, PIN_PULLUP;
    integer     err_count = 0, compares = 0;
    always #25 CLK_SYS = ~CLK_SYS;
    gpsync_port gpsync_port_i (.CLK_SYS(CLK_SYS), .RST_N(RST_N),
        .AWADDR(AWADDR), .AWVALID(AWVALID), .AWREADY(AWREADY),
        .WDATA(WDATA), .WSTRB(4'hF), .WVALID(WVALID), .WREADY(WREADY),
        .BRESP(BRESP), .BVALID(BVALID), .BREADY(BREADY), .ARADDR(ARADDR),
        .ARVALID(ARVALID), .ARREADY(ARREADY), .RDATA(RDATA), .RRESP(RRESP),
        .RVALID(RVALID), .RREADY(RREADY), .PIN_IN(PIN_IN),
        .PIN_OUT(PIN_OUT), .PIN_OE_N(PIN_OE_N), .PIN_PULLUP(PIN_PULLUP),
        .SLEEP_DEEP(SLEEP_DEEP), .ALT_INPUT_KEEP(ALT_INPUT_KEEP),
        .EXT_INT_FLAG(EXT_INT_FLAG));
    gpsync_pins gpsync_pins_i (.pin_out(PIN_OUT), .pin_oe_n(PIN_OE_N),
        .pin_pullup(PIN_PULLUP), .ext_level(ext_level), .pin_in(PIN_IN));
    // =====================================================================
    // Closing, comparison and bus tasks
    task complete_run;
        begin
            $display("compares %0d mismatches %0d", compares, err_count);
            if (err_count == 0 && compares > 0)
                $display("Regression OK");
            else
                $display("Regression broken");
            $finish;
        end
    endtask
    task chk(input string nm, input [31:0] seen, input [31:0] exp);
        begin
            compares = compares + 1;
            if (seen !== exp) begin
                err_count = err_count + 1;
                $display("FAIL %s expected %h seen %h", nm, exp, seen);
            end
        end
    endtask
    // Handshakes are judged at the falling edge, so the next rising edge
    // never races the slave's own update; ready follows valid a cycle late.
    task wr(input [7:0] a, input [31:0] d, input [1:0] e);
        integer n;
        reg     aw_t, w_t, bv, b_t;
        begin
            AWADDR <= a; WDATA <= d; AWVALID <= 1'b1; WVALID <= 1'b1;
            b_t = 1'b0;
            for (n = 0; !b_t && n < 40; n = n + 1) begin
                @(negedge CLK_SYS);
                aw_t = AWVALID && AWREADY;
                w_t = WVALID && WREADY;
                bv = BVALID;
                b_t = BVALID && BREADY;
                if (b_t) chk("bresp", BRESP, e);
                @(posedge CLK_SYS);
                if (aw_t) AWVALID <= 1'b0;
                if (w_t) WVALID <= 1'b0;
                BREADY <= bv && !b_t;
            end
            if (!b_t) begin err_count = err_count + 1; complete_run; end
        end
    endtask
    task rd(input string nm, input [7:0] a, input [31:0] x, input [1:0] e);
        integer n;
        reg     ar_t, rv, r_t;
        begin
            ARADDR <= a; ARVALID <= 1'b1;
            r_t = 1'b0;
            for (n = 0; !r_t && n < 40; n = n + 1) begin
                @(negedge CLK_SYS);
                ar_t = ARVALID && ARREADY;
                rv = RVALID;
                r_t = RVALID && RREADY;
                if (r_t) chk(nm, RDATA, x);
                if (r_t) chk("rresp", RRESP, e);
                @(posedge CLK_SYS);
                if (ar_t) ARVALID <= 1'b0;
                RREADY <= rv && !r_t;
            end
            if (!r_t) begin err_count = err_count + 1; complete_run; end
        end
    endtask
    // =====================================================================
    // Main sequence
    initial begin
        repeat (3) @(posedge CLK_SYS);
        chk("oe_rst", PIN_OE_N, 8'hFF);
        chk("pull_rst", PIN_PULLUP, 8'h00);
        @(posedge CLK_SYS) RST_N <= 1'b1;
        rd("dir", `GPS_OFF_DIR, 0, `GPS_RESP_OKAY);
        rd("drv", `GPS_OFF_DRV, 0, `GPS_RESP_OKAY);
        rd("sense", `GPS_OFF_SENSE, 8'hA5, `GPS_RESP_OKAY);
        $display("test reset done");
        // Tri-state to output-high via pull-up input.
        wr(`GPS_OFF_DRV, 8'hFF, `GPS_RESP_OKAY);
        chk("pull", PIN_PULLUP, 8'hFF);
        wr(`GPS_OFF_DIR, 8'hFF, `GPS_RESP_OKAY);
        chk("oe", PIN_OE_N, 8'h00);
        chk("pull", PIN_PULLUP, 8'h00);
        chk("out", PIN_OUT, 8'hFF);
        // Low pins and pull-up pins never swap in one write.
        wr(`GPS_OFF_DRV_CLR, 8'h0F, `GPS_RESP_OKAY);
        chk("out", PIN_OUT, 8'hF0);
        wr(`GPS_OFF_DIR_CLR, 8'hF0, `GPS_RESP_OKAY);
        rd("sense", `GPS_OFF_SENSE, 8'hF0, `GPS_RESP_OKAY);
        rd("dir", `GPS_OFF_DIR, 8'h0F, `GPS_RESP_OKAY);
        wr(`GPS_OFF_SPECIAL, 8'h04, `GPS_RESP_OKAY);
        chk("pull_off", PIN_PULLUP, 8'h00);
        rd("sense", `GPS_OFF_SENSE, 8'hA0, `GPS_RESP_OKAY);
        wr(`GPS_OFF_SPECIAL, 8'h00, `GPS_RESP_OKAY);
        wr(`GPS_OFF_SENSE, 8'hFF, `GPS_RESP_SLVERR);
        rd("bad", 8'h30, `GPS_RDATA_ZERO, `GPS_RESP_SLVERR);
        $display("test config done");
        wr(`GPS_OFF_DRV_SET, 8'h02, `GPS_RESP_OKAY);
        wr(`GPS_OFF_INT_CFG, 32'h00000200, `GPS_RESP_OKAY);
        @(posedge CLK_SYS) SLEEP_DEEP <= 1'b1;
        repeat (3) @(posedge CLK_SYS);
        chk("flag", EXT_INT_FLAG, 2'h2);
        rd("clamp", `GPS_OFF_SENSE, 8'h00, `GPS_RESP_OKAY);
        ALT_INPUT_KEEP <= 8'hFF;
        @(posedge CLK_SYS);
        rd("keep", `GPS_OFF_SENSE, 8'hF2, `GPS_RESP_OKAY);
        ALT_INPUT_KEEP <= 8'h00;
        wr(`GPS_OFF_INT_CFG, 32'h00000003, `GPS_RESP_OKAY);
        rd("irq_pin", `GPS_OFF_SENSE, 8'h02, `GPS_RESP_OKAY);
        wr(`GPS_OFF_INT_FLAG, 8'h03, `GPS_RESP_OKAY);
        chk("flag_clr", EXT_INT_FLAG, 2'h0);
        SLEEP_DEEP <= 1'b0;
        $display("test sleep done");
        // Reset lands between edges, so only the asynchronous path acts.
        #10 RST_N = 1'b0;
        #1 chk("oe_async", PIN_OE_N, 8'hFF);
        chk("pull_async", PIN_PULLUP, 8'h00);
        @(posedge CLK_SYS) RST_N <= 1'b1;
        @(posedge CLK_SYS);
        rd("dir", `GPS_OFF_DIR, 0, `GPS_RESP_OKAY);
        $display("test second reset done");
        complete_run;
    end
endmodule
